// ==== core/qpss_pkg.sv ====
// Purpose: Constants for the quad pot serial slave
// Assumes: core_clk at 100 MHz
// Notes: Times are in microseconds, counts in core_clk cycles
package qpss_pkg;
  localparam int CLK_MHZ = 100;
  localparam int NV_WRITE_TIME_US = 5000;
  localparam int NV_WRITE_MAX_US = 10000;
  localparam int NV_WRITE_CYCLES = NV_WRITE_TIME_US * CLK_MHZ;
  localparam int WIPER_SETTLE_DELAY_US = 1;
  localparam int WIPER_SETTLE_CYCLES = WIPER_SETTLE_DELAY_US * CLK_MHZ;
  localparam logic [3:0] DEV_TYPE_CODE = 4'h0; // Arbitrary device-type value
  localparam logic [3:0] OP_RD_WCR = 4'h9;
  localparam logic [3:0] OP_WR_WCR = 4'ha;
  localparam logic [3:0] OP_RD_DR = 4'hb;
  localparam logic [3:0] OP_WR_DR = 4'hc;
  localparam logic [3:0] OP_DR2WC = 4'hd;
  localparam logic [3:0] OP_WC2DR = 4'he;
  localparam logic [3:0] OP_GDR2WC = 4'h1;
  localparam logic [3:0] OP_GWC2DR = 4'h8;
  localparam logic [3:0] OP_INCDEC = 4'h2;
  localparam int CASCADE_ENABLE_BIT = 7;
  localparam int WIPER_DISABLE_BIT = 6;
  localparam logic [5:0] TAP_TOP = 6'h3f;
  localparam logic [7:0] DR_RESET = 8'h00;
  typedef enum logic [6:0] {
    QPSS_IDLE = 7'h01,
    QPSS_ADDR = 7'h02,
    QPSS_INSTR = 7'h04,
    QPSS_WDATA = 7'h08,
    QPSS_RDATA = 7'h10,
    QPSS_STEP = 7'h20,
    QPSS_WAIT = 7'h40
  } qpss_state_t;
endpackage : qpss_pkg

// ==== core/qpss_slave.sv ====
// Purpose: Two-wire slave and instruction handler for a quad pot
// Assumes: Bus lines asynchronous to core_clk, sampled through two flops
// Notes: Data registers are held in flops; nonvolatile write is timed only
`timescale 1ns/1ps
module qpss_slave
  import qpss_pkg::*;
#(
  parameter int NV_CYCLES = NV_WRITE_CYCLES,
  parameter int SETTLE_CYCLES = WIPER_SETTLE_CYCLES
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic [3:0] deviceAddrPins,
  output logic [63:0] tapSelect [4],
  output logic [3:0] wiperEnable,
  output logic [3:0] cascadeEnable,
  output logic nvBusy
);
  // Settle counters are 16 bits wide
  if (NV_CYCLES < 1 || NV_CYCLES > NV_WRITE_MAX_US * CLK_MHZ ||
      SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65536) begin : g_bad_timing
    $error("qpss_slave: bad timing parameters");
  end

  // ****************************************
  // Bus sampling and condition detect
  // ****************************************
  logic [1:0] sclSync_q;
  logic [1:0] sdaSync_q;
  logic sclPrev_q;
  logic sdaPrev_q;
  logic [3:0] addrMeta_q;
  logic [3:0] addrPins_q;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclSync_q <= 2'h3;
      sdaSync_q <= 2'h3;
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
      addrMeta_q <= 4'h0;
      addrPins_q <= 4'h0;
    end else begin
      sclSync_q <= {sclSync_q[0], sclIn};
      sdaSync_q <= {sdaSync_q[0], sdaIn};
      sclPrev_q <= sclSync_q[1];
      sdaPrev_q <= sdaSync_q[1];
      addrMeta_q <= deviceAddrPins;
      addrPins_q <= addrMeta_q;
    end
  end
  logic scl;
  logic sda;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  assign scl = sclSync_q[1];
  assign sda = sdaSync_q[1];
  assign sclRise = scl && !sclPrev_q;
  assign sclFall = !scl && sclPrev_q;
  assign startCond = scl && sclPrev_q && sdaPrev_q && !sda;
  assign stopCond = scl && sclPrev_q && !sdaPrev_q && sda;

  // ****************************************
  // Byte engine and sequencer
  // ****************************************
  qpss_state_t state_q;
  logic [3:0] bitCnt_q;
  logic [7:0] shift_q;
  logic [7:0] instr_q;
  logic [7:0] txByte_q;
  logic ackPhase_q;
  logic ackDrive_q;
  logic txDrive_q;
  logic nvPending_q;
  logic [7:0] wiperCounter [4];
  logic [7:0] potDataRegisters [4][4];
  logic [31:0] nvCnt_q;
  logic inputsOff;
  logic [3:0] opcode;
  logic [1:0] potSel;
  logic [1:0] regSel;
  logic byteDone;
  logic [7:0] rxByte;
  assign opcode = instr_q[7:4];
  assign potSel = instr_q[3:2];
  assign regSel = instr_q[1:0];
  assign inputsOff = nvBusy;
  assign byteDone = sclRise && (bitCnt_q == 4'h7) && !ackPhase_q;
  assign rxByte = {shift_q[6:0], sda};

  function automatic logic isNvOp(input logic [3:0] op);
    return op == OP_WR_DR || op == OP_WC2DR || op == OP_GWC2DR;
  endfunction : isNvOp

  function automatic logic [7:0] stepWiper(input logic [7:0] w, input logic up);
    logic [5:0] t;
    t = w[5:0];
    if (up && t != TAP_TOP) begin
      t = t + 6'h01;
    end else if (!up && t != 6'h00) begin
      t = t - 6'h01;
    end
    return {w[7:6], t};
  endfunction : stepWiper

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= QPSS_IDLE;
      bitCnt_q <= 4'h0;
      shift_q <= 8'h00;
      instr_q <= 8'h00;
      ackPhase_q <= 1'b0;
      nvPending_q <= 1'b0;
    end else if (startCond) begin
      state_q <= QPSS_ADDR;
      bitCnt_q <= 4'h0;
      ackPhase_q <= 1'b0;
    end else if (stopCond) begin
      state_q <= QPSS_IDLE;
      nvPending_q <= 1'b0;
    end else begin
      case (state_q)
        QPSS_IDLE, QPSS_WAIT: begin
        end
        QPSS_STEP: begin
        end
        default: begin
          if (sclRise && !ackPhase_q) begin
            shift_q <= rxByte;
            bitCnt_q <= bitCnt_q + 4'h1;
          end else if (sclRise) begin
            // Count the ninth clock so the ack bit is never shifted in
            bitCnt_q <= 4'h9;
          end
          if (byteDone) begin
            ackPhase_q <= 1'b1;
            case (state_q)
              QPSS_ADDR: begin
                if (rxByte != {DEV_TYPE_CODE, addrPins_q} || inputsOff) begin
                  state_q <= QPSS_WAIT;
                end
              end
              QPSS_INSTR: instr_q <= rxByte;
              QPSS_WDATA: nvPending_q <= isNvOp(opcode);
              default: begin
              end
            endcase
          end
          if (sclFall && ackPhase_q && bitCnt_q == 4'h9) begin
            ackPhase_q <= 1'b0;
            bitCnt_q <= 4'h0;
            case (state_q)
              QPSS_ADDR: state_q <= QPSS_INSTR;
              QPSS_INSTR: begin
                case (opcode)
                  OP_WR_WCR, OP_WR_DR: state_q <= QPSS_WDATA;
                  OP_RD_WCR, OP_RD_DR: state_q <= QPSS_RDATA;
                  OP_INCDEC: state_q <= QPSS_STEP;
                  OP_DR2WC, OP_GDR2WC: state_q <= QPSS_WAIT;
                  OP_WC2DR, OP_GWC2DR: begin
                    state_q <= QPSS_WAIT;
                    nvPending_q <= 1'b1;
                  end
                  default: state_q <= QPSS_WAIT;
                endcase
              end
              default: state_q <= QPSS_WAIT;
            endcase
          end
        end
      endcase
    end
  end

  // Ack window runs from the fall after bit 8 to the fall after bit 9
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ackDrive_q <= 1'b0;
    end else if (startCond || stopCond) begin
      ackDrive_q <= 1'b0;
    end else if (sclFall && ackDrive_q) begin
      ackDrive_q <= 1'b0;
    end else if (sclFall && ackPhase_q && bitCnt_q == 4'h8 && state_q != QPSS_WAIT) begin
      ackDrive_q <= state_q != QPSS_RDATA;
    end
  end

  // Read data: first bit placed on the fall closing the instruction ack
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      txByte_q <= 8'h00;
      txDrive_q <= 1'b0;
    end else if (startCond || stopCond) begin
      txDrive_q <= 1'b0;
    end else if (sclFall && state_q == QPSS_INSTR && ackPhase_q && bitCnt_q == 4'h9 &&
                 (opcode == OP_RD_WCR || opcode == OP_RD_DR)) begin
      txByte_q <= (opcode == OP_RD_WCR) ? wiperCounter[potSel] : potDataRegisters[potSel][regSel];
      txDrive_q <= 1'b1;
    end else if (sclFall && state_q == QPSS_RDATA && !ackPhase_q) begin
      txByte_q <= {txByte_q[6:0], 1'b0};
      txDrive_q <= bitCnt_q != 4'h8;
    end else if (sclFall && state_q == QPSS_RDATA) begin
      txDrive_q <= 1'b0;
    end
  end

  // ****************************************
  // Registers, stepping and nonvolatile timer
  // ****************************************
  logic stepPulse_q;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stepPulse_q <= 1'b0;
    end else begin
      stepPulse_q <= state_q == QPSS_STEP && sclRise;
    end
  end
  logic sdaAtRise_q;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sdaAtRise_q <= 1'b0;
    end else if (sclRise) begin
      sdaAtRise_q <= sda;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int p = 0; p < 4; p++) begin
        for (int r = 0; r < 4; r++) begin
          potDataRegisters[p][r] <= DR_RESET;
        end
        wiperCounter[p] <= DR_RESET;
      end
    end else begin
      // A stop or start ends stepping, so a held-high line during stop is not a step
      if (stepPulse_q && !stopCond && !startCond) begin
        wiperCounter[potSel] <= stepWiper(wiperCounter[potSel], sdaAtRise_q);
      end
      if (sclFall && ackPhase_q && bitCnt_q == 4'h9) begin
        if (state_q == QPSS_INSTR) begin
          case (opcode)
            OP_DR2WC: wiperCounter[potSel] <= potDataRegisters[potSel][regSel];
            OP_GDR2WC: begin
              for (int p = 0; p < 4; p++) begin
                wiperCounter[p] <= potDataRegisters[p][regSel];
              end
            end
            OP_WC2DR: potDataRegisters[potSel][regSel] <= wiperCounter[potSel];
            OP_GWC2DR: begin
              for (int p = 0; p < 4; p++) begin
                potDataRegisters[p][regSel] <= wiperCounter[p];
              end
            end
            default: begin
            end
          endcase
        end else if (state_q == QPSS_WDATA) begin
          if (opcode == OP_WR_WCR) begin
            wiperCounter[potSel] <= shift_q;
          end else begin
            potDataRegisters[potSel][regSel] <= shift_q;
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      nvCnt_q <= 32'h0;
      nvBusy <= 1'b0;
    end else if (stopCond && nvPending_q && !nvBusy) begin
      nvCnt_q <= 32'(NV_CYCLES);
      nvBusy <= 1'b1;
    end else if (nvBusy) begin
      nvCnt_q <= nvCnt_q - 32'h1;
      nvBusy <= nvCnt_q != 32'h1;
    end
  end

  // ****************************************
  // Pin and tap outputs
  // ****************************************
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sdaOe <= 1'b0;
      sdaOut <= 1'b0;
    end else begin
      sdaOut <= 1'b0;
      sdaOe <= !inputsOff && (ackDrive_q || (txDrive_q && !txByte_q[7]));
    end
  end

  // Settle counters delay the visible tap after a counter change
  logic [15:0] settleCnt_q [4];
  logic [7:0] shownWiper_q [4];
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int p = 0; p < 4; p++) begin
        settleCnt_q[p] <= 16'h0;
        shownWiper_q[p] <= DR_RESET;
        tapSelect[p] <= 64'h1;
        wiperEnable[p] <= 1'b1;
        cascadeEnable[p] <= 1'b0;
      end
    end else begin
      for (int p = 0; p < 4; p++) begin
        if (shownWiper_q[p] != wiperCounter[p]) begin
          if (settleCnt_q[p] == 16'(SETTLE_CYCLES - 1)) begin
            shownWiper_q[p] <= wiperCounter[p];
            settleCnt_q[p] <= 16'h0;
          end else begin
            settleCnt_q[p] <= settleCnt_q[p] + 16'h1;
          end
        end else begin
          settleCnt_q[p] <= 16'h0;
        end
        tapSelect[p] <= 64'h1 << shownWiper_q[p][5:0];
        wiperEnable[p] <= !shownWiper_q[p][WIPER_DISABLE_BIT];
        cascadeEnable[p] <= shownWiper_q[p][CASCADE_ENABLE_BIT];
      end
    end
  end
endmodule : qpss_slave

// ==== test/qpss_slave_monitor.sv ====
// Purpose: Port checks for the quad pot serial slave
// Assumes: Bound to qpss_slave, bus lines slower than core_clk
// Notes: Busy length allows one cycle of slack
`timescale 1ns/1ps
module qpss_slave_monitor
  import qpss_pkg::*;
#(
  parameter int NV_CYCLES = NV_WRITE_CYCLES
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic [3:0] deviceAddrPins,
  input wire logic [63:0] tapSelect [4],
  input wire logic [3:0] wiperEnable,
  input wire logic [3:0] cascadeEnable,
  input wire logic nvBusy
);
  // ****************
  // Busy length
  // ****************
  int busyCnt_q;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busyCnt_q <= 0;
    end else begin
      busyCnt_q <= nvBusy ? busyCnt_q + 1 : 0;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence sclLowLong;
    !sclIn && !$past(sclIn, 2);
  endsequence
  sequence stopLevels;
    sclIn && sdaIn;
  endsequence
  open_drain_a: assert property (sdaOut == 1'b0)
    else $error("data line driven high");
  one_tap_a: assert property ($onehot(tapSelect[0]) && $onehot(tapSelect[1])
    && $onehot(tapSelect[2]) && $onehot(tapSelect[3])) else $error("tap select not one-hot");
  hold_high_a: assert property (sclIn |-> $stable(sdaOe))
    else $error("data drive changed with clock high");
  ack_edge_a: assert property ($rose(sdaOe) |-> sclLowLong)
    else $error("drive began too soon after clock fall");
  busy_noack_a: assert property (nvBusy |-> !sdaOe)
    else $error("drive while write busy");
  busy_start_a: assert property ($rose(nvBusy) |-> stopLevels)
    else $error("busy began outside a stop");
  busy_len_a: assert property ($fell(nvBusy) |-> busyCnt_q >= NV_CYCLES - 1 && busyCnt_q <= NV_CYCLES + 1)
    else $error("write cycle length wrong");
  busy_max_a: assert property (busyCnt_q <= 2 * NV_CYCLES)
    else $error("write cycle too long");
  reset_state_a: assert property ($past(sys_rst) |-> tapSelect[0] == 64'h1 && wiperEnable == 4'hf
    && cascadeEnable == 4'h0 && !nvBusy) else $error("state after reset wrong");
endmodule : qpss_slave_monitor

bind qpss_slave qpss_slave_monitor #(.NV_CYCLES(NV_CYCLES)) i_mon (
  .core_clk(core_clk), .sys_rst(sys_rst), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
  .sdaOe(sdaOe), .deviceAddrPins(deviceAddrPins), .tapSelect(tapSelect),
  .wiperEnable(wiperEnable), .cascadeEnable(cascadeEnable), .nvBusy(nvBusy));

// ==== test/qpss_master.sv ====
// Purpose: Two-wire bus master model
// Assumes: Line has a pull-up; model only pulls low
// Notes: Quarter-period timing, 125 ns bit
`timescale 1ns/1ps
module qpss_master (
  output logic scl,
  output logic sdaPull,
  input wire logic sda
);
  localparam realtime Q = 31.25;
  initial begin
    scl = 1'b1;
    sdaPull = 1'b0;
  end
  task automatic put(input logic b, output logic r);
    sdaPull = !b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
    #Q;
  endtask : put
  task automatic start();
    #Q sdaPull = 1'b0;
    #Q scl = 1'b1;
    #Q sdaPull = 1'b1;
    #Q scl = 1'b0;
  endtask : start
  task automatic stop();
    #Q sdaPull = 1'b1;
    #Q scl = 1'b1;
    #Q sdaPull = 1'b0;
    #Q;
  endtask : stop
  task automatic wr(input logic [7:0] d, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) put(d[i], r);
    put(1'b1, r);
    a = !r;
  endtask : wr
  task automatic rd(input logic nak, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put(1'b1, r);
      d[i] = r;
    end
    put(nak, r);
  endtask : rd
endmodule : qpss_master

// ==== test/quad_pot_serial_slave_bench.sv ====
// Purpose: Self-checking bench for the quad pot serial slave
// Assumes: Short write cycle and settle counts
// Notes: Expected values queued by the driver, checked by a watcher
`timescale 1ns/1ps
module quad_pot_serial_slave_bench
  import qpss_pkg::*;
;
  localparam int NVC = 400;
  logic core_clk, sys_rst, scl, pull, sdaOut, sdaOe, nvBusy;
  logic [3:0] pins, wiperEnable, cascadeEnable;
  logic [63:0] tapSelect [4];
  logic [1:0] p, q, r, r2;
  logic [7:0] v, d, w, gotV;
  logic [7:0] expQ [$];
  wire sdaLine = !(pull || (sdaOe && !sdaOut));
  int n_fail, n_compared, cyc;
  event seen;
  qpss_slave #(.NV_CYCLES(NVC), .SETTLE_CYCLES(2)) i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .deviceAddrPins(pins),
    .tapSelect(tapSelect), .wiperEnable(wiperEnable), .cascadeEnable(cascadeEnable), .nvBusy(nvBusy));
  qpss_master i_m (.scl(scl), .sdaPull(pull), .sda(sdaLine));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic wrap_up();
    if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic note(input logic [7:0] e);
    expQ.push_back(e);
  endtask : note
  task automatic look(input logic [7:0] g);
    gotV = g;
    ->seen;
    #1;
  endtask : look
  initial forever begin
    @(seen);
    n_compared++;
    if (expQ.size() == 0 || gotV !== expQ[0]) begin
      n_fail++;
      $display("BAD %0t got %h", $time, gotV);
    end
    if (expQ.size() != 0) void'(expQ.pop_front());
  end
  function automatic logic [7:0] shown(input int k);
    logic [7:0] s;
    s = {cascadeEnable[k], !wiperEnable[k], 6'h00};
    for (int i = 0; i < 64; i++) if (tapSelect[k][i]) s[5:0] = s[5:0] | 6'(i);
    return s;
  endfunction : shown
  // Mode 0 no data byte, 1 write byte, 2 read byte compared with e
  task automatic cmd(input logic [3:0] ad, input logic [7:0] ins, input int mode, input logic [7:0] e);
    logic a, ok;
    logic [7:0] g;
    ok = (ad === pins) && (nvBusy === 1'b0);
    i_m.start();
    note({7'h00, ok});
    i_m.wr({DEV_TYPE_CODE, ad}, a);
    look({7'h00, a});
    if (ok) begin
      note(8'h01);
      i_m.wr(ins, a);
      look({7'h00, a});
      if (mode == 1) begin
        note(8'h01);
        i_m.wr(e, a);
        look({7'h00, a});
      end
      if (mode == 2) begin
        note(e);
        i_m.rd(1'b1, g);
        look(g);
      end
    end
    i_m.stop();
  endtask : cmd
  task automatic poll();
    int k;
    for (k = 0; k < 20 && nvBusy !== 1'b1; k++) @(posedge core_clk);
    note(8'h01);
    look({7'h00, nvBusy});
    cmd(pins, 8'h00, 0, 8'h00);
    for (k = 0; k < 2000 && nvBusy !== 1'b0; k++) @(posedge core_clk);
    cmd(pins, 8'h00, 0, 8'h00);
  endtask : poll
  // Up ends in a start so the final rise steps up, down ends in a stop
  task automatic step(input logic [1:0] k, input logic up, input int n);
    logic a;
    i_m.start();
    i_m.wr({DEV_TYPE_CODE, pins}, a);
    i_m.wr({OP_INCDEC, k, 2'b00}, a);
    repeat (n) i_m.put(up, a);
    if (up) i_m.start();
    i_m.stop();
    repeat (10) @(posedge core_clk);
    note(up ? TAP_TOP : 8'h00);
    look(shown(k));
  endtask : step
  // ****************
  // Main sequence
  // ****************
  initial begin
    sys_rst = 1'b1;
    pins = 4'h0;
    void'($urandom(79));
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    pins <= 4'($urandom);
    {p, r, v, d, w} = 28'($urandom);
    q = p ^ 2'b01;
    r2 = r + 2'b01;
    repeat (4) @(posedge core_clk);
    note(8'h00);
    look(shown(0));
    cmd(~pins, {OP_RD_WCR, 4'h0}, 0, 8'h00);
    cmd(pins, {OP_WR_WCR, p, 2'b00}, 1, v);
    repeat (10) @(posedge core_clk);
    note(v);
    look(shown(p));
    cmd(pins, {OP_RD_WCR, p, 2'b00}, 2, v);
    cmd(pins, {OP_WR_DR, p, r}, 1, d);
    poll();
    cmd(pins, {OP_RD_DR, p, r}, 2, d);
    cmd(pins, {OP_DR2WC, p, r}, 0, 8'h00);
    repeat (10) @(posedge core_clk);
    note(d);
    look(shown(p));
    cmd(pins, {OP_WR_WCR, p, 2'b00}, 1, 8'h3e);
    step(p, 1'b1, 3);
    cmd(pins, {OP_WC2DR, p, r2}, 0, 8'h00);
    poll();
    cmd(pins, {OP_RD_DR, p, r2}, 2, 8'h3f);
    step(p, 1'b0, 66);
    cmd(pins, {OP_WR_WCR, q, 2'b00}, 1, w);
    cmd(pins, {OP_GWC2DR, 2'b00, r2}, 0, 8'h00);
    poll();
    cmd(pins, {OP_GDR2WC, 2'b00, r}, 0, 8'h00);
    repeat (10) @(posedge core_clk);
    for (int i = 0; i < 4; i++) begin
      note(i == p ? d : 8'h00);
      look(shown(i));
    end
    cmd(pins, {OP_RD_DR, q, r2}, 2, w);
    wrap_up();
  end
endmodule : quad_pot_serial_slave_bench
